// ===== logic/capture_defs.svh
// Register offsets, field positions and reset values of the capture block.
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH
`define CAP_MODE_OFFSET 4'h0
`define CAP_ENABLE_OFFSET 4'h4
`define CAP_STATUS_OFFSET 4'h8
`define CAP_MODE_RESET 16'h0000
`define CAP_ENABLE_RESET 2'h0
`define CAP_FIELD_STRIDE 8
`define CAP_DIR_LSB 0
`define CAP_PSC_LSB 2
`define CAP_FLT_LSB 4
`define CAP_STATUS_ACTIVE_LSB 2
`define CAP_FLT_BYPASS 4'h0
`endif

// ===== logic/capture_filter.sv
// Digital input filter with clock-divided sampling and a run-length count.
`timescale 1ns/10ps
`include "capture_defs.svh"
module capture_filter import capture_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] code,
	input wire logic din,
	output logic level
);
	flt_s s_q, s_d;
	logic [4:0] div_mask;
	logic tick;

	assign div_mask = 5'((6'h1 << flt_div_log2(code)) - 6'h1);
	assign tick = (s_q.div_cnt == div_mask);
	assign level = s_q.level;

	always_comb begin
		s_d = s_q;
		if (tick) begin
			s_d.div_cnt = 5'h0;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 5'h1;
		end
		if (code == `CAP_FLT_BYPASS) begin
			s_d.level = din;
			s_d.run = 4'h0;
		end else if (tick) begin
			if (din == s_q.level) begin
				s_d.run = 4'h0;
			end else if (s_q.run + 4'h1 >= flt_count(code)) begin
				s_d.level = din;
				s_d.run = 4'h0;
			end else begin
				s_d.run = s_q.run + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_flt_bypass_follow: assert property (code == `CAP_FLT_BYPASS |=> level == $past(din)) else $error("bypass filter did not follow input");
	a_flt_run_length: assert property ((code != `CAP_FLT_BYPASS && $past(code) == code && $past(code, 2) == code) ##0 $changed(level) |-> $past(s_q.run) + 4'h1 >= flt_count(code) && $past(tick)) else $error("filter level moved before run completed");
	a_flt_sample_rate: assert property (!tick && code == $past(code) |=> $stable(s_q.run)) else $error("filter counted between sample ticks");
	a_flt_table_top: assert property (code == 4'hf |-> div_mask == 5'h1f && flt_count(code) == 4'h8) else $error("filter code 15 decode wrong");
	c_flt_transition: cover property (code != `CAP_FLT_BYPASS ##0 $rose(level));
endmodule : capture_filter

// ===== logic/capture_pkg.sv
// Types and decode functions shared by the capture channel modules.
package capture_pkg;
	typedef enum logic [1:0] {DIR_OUTPUT, DIR_TI_ONE, DIR_TI_TWO, DIR_TRIGGER} dir_e;

	typedef struct packed {
		logic [4:0] div_cnt;
		logic [3:0] run;
		logic level;
	} flt_s;

	typedef struct packed {
		logic [2:0] count;
		logic capture;
	} psc_s;

	typedef struct packed {
		logic [15:0] mode;
		logic [1:0] en;
		logic wait_req;
		logic [31:0] rdata;
		logic [1:0] cfg_wr;
		logic [1:0] lvl_prev;
	} top_s;

	// Sample divider as a power of two, 0 meaning every clock.
	function automatic logic [2:0] flt_div_log2(input logic [3:0] code);
		case (code)
			4'h4, 4'h5: flt_div_log2 = 3'h1;
			4'h6, 4'h7: flt_div_log2 = 3'h2;
			4'h8, 4'h9: flt_div_log2 = 3'h3;
			4'ha, 4'hb, 4'hc: flt_div_log2 = 3'h4;
			4'hd, 4'he, 4'hf: flt_div_log2 = 3'h5;
			default: flt_div_log2 = 3'h0;
		endcase
	endfunction : flt_div_log2

	function automatic logic [3:0] flt_count(input logic [3:0] code);
		case (code)
			4'h1: flt_count = 4'h2;
			4'h2: flt_count = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hb, 4'he: flt_count = 4'h6;
			4'ha, 4'hd: flt_count = 4'h5;
			4'h0: flt_count = 4'h1;
			default: flt_count = 4'h8;
		endcase
	endfunction : flt_count

	function automatic logic [3:0] psc_factor(input logic [1:0] code);
		psc_factor = 4'(4'h1 << code);
	endfunction : psc_factor
endpackage : capture_pkg

// ===== logic/capture_prescaler.sv
// Capture event prescaler: one capture for every group of valid events.
`timescale 1ns/10ps
module capture_prescaler import capture_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic [1:0] code,
	input wire logic event_in,
	output logic capture
);
	psc_s s_q, s_d;

	assign capture = s_q.capture;

	always_comb begin
		s_d = s_q;
		s_d.capture = 1'b0;
		if (restart) begin
			s_d.count = 3'h0;
		end else if (event_in) begin
			if ({1'b0, s_q.count} == psc_factor(code) - 4'h1) begin
				s_d.count = 3'h0;
				s_d.capture = 1'b1;
			end else begin
				s_d.count = s_q.count + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_psc_group_end: assert property ($rose(capture) |-> $past(event_in) && !$past(restart) && {1'b0, $past(s_q.count)} == psc_factor($past(code)) - 4'h1) else $error("capture without full event group");
	a_psc_divide_one: assert property (code == 2'h0 && event_in && !restart |=> capture) else $error("factor one did not capture every event");
	a_psc_restart_clear: assert property (restart |=> s_q.count == 3'h0 && !capture) else $error("restart did not clear event count");
	c_psc_eight: cover property (code == 2'h3 ##0 capture);
endmodule : capture_prescaler

// ===== logic/input_capture_channel_config.sv
// Two input-capture channel front ends with an Avalon-MM register slave.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "capture_defs.svh"
module input_capture_channel_config import capture_pkg::*; (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic TIMER_INPUT_ONE,
	input wire logic TIMER_INPUT_TWO,
	input wire logic TRIGGER_CAPTURE_SOURCE,
	input wire logic TRIGGER_INPUT_IN_USE,
	output logic [1:0] CAPTURE,
	output logic [1:0] FILTERED_LEVEL
);
	top_s s_q, s_d;
	logic [1:0] sel_in;
	logic [1:0] active;
	logic [1:0] flt_lvl;
	logic [1:0] cap;
	logic access;
	logic hit_mode;
	logic hit_enable;
	logic [15:0] wmask;
	logic [15:0] lock_mask;
	localparam logic [3:0] mode_adr = `CAP_MODE_OFFSET;
	localparam logic [3:0] enable_adr = `CAP_ENABLE_OFFSET;
	localparam logic [3:0] status_adr = `CAP_STATUS_OFFSET;

	assign access = (AVS_READ || AVS_WRITE) && !s_q.wait_req;
	assign hit_mode = AVS_ADDRESS[3:2] == mode_adr[3:2];
	assign hit_enable = AVS_ADDRESS[3:2] == enable_adr[3:2];
	assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	assign AVS_READDATA = s_q.rdata;
	assign AVS_WAITREQUEST = s_q.wait_req;
	assign CAPTURE = cap;
	assign FILTERED_LEVEL = flt_lvl;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			localparam int B = ch * `CAP_FIELD_STRIDE;
			dir_e dir;
			logic [1:0] psc_code;
			logic [3:0] flt_code;
			assign dir = dir_e'(s_q.mode[B + `CAP_DIR_LSB +: 2]);
			assign psc_code = s_q.mode[B + `CAP_PSC_LSB +: 2];
			assign flt_code = s_q.mode[B + `CAP_FLT_LSB +: 4];
			// Direction bits are frozen while the channel runs.
			assign lock_mask[B +: 8] = {6'h00, {2{s_q.en[ch]}}};
			always_comb begin
				case (dir)
					DIR_TI_ONE: sel_in[ch] = TIMER_INPUT_ONE;
					DIR_TI_TWO: sel_in[ch] = TIMER_INPUT_TWO;
					DIR_TRIGGER: sel_in[ch] = TRIGGER_CAPTURE_SOURCE;
					default: sel_in[ch] = 1'b0;
				endcase
			end
			// The trigger path is dead unless an internal trigger is in use.
			assign active[ch] = s_q.en[ch] && dir != DIR_OUTPUT &&
				(dir != DIR_TRIGGER || TRIGGER_INPUT_IN_USE);
			capture_filter u_filter (
				.clk(CLK),
				.rst(RST),
				.code(flt_code),
				.din(sel_in[ch]),
				.level(flt_lvl[ch])
			);
			capture_prescaler u_prescaler (
				.clk(CLK),
				.rst(RST),
				.restart(!active[ch] || s_q.cfg_wr[ch]),
				.code(psc_code),
				.event_in(active[ch] && flt_lvl[ch] && !s_q.lvl_prev[ch]),
				.capture(cap[ch])
			);
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.cfg_wr = 2'h0;
		s_d.lvl_prev = flt_lvl;
		// One wait state per access keeps read data a registered output.
		s_d.wait_req = !((AVS_READ || AVS_WRITE) && s_q.wait_req);
		if (access && AVS_WRITE && hit_mode) begin
			s_d.mode = (s_q.mode & ~(wmask & ~lock_mask)) |
				(AVS_WRITEDATA[15:0] & wmask & ~lock_mask);
			s_d.cfg_wr = {|wmask[15:8], |wmask[7:0]};
		end
		if (access && AVS_WRITE && hit_enable && AVS_BYTEENABLE[0]) begin
			s_d.en = AVS_WRITEDATA[1:0];
		end
		if ((AVS_READ || AVS_WRITE) && s_q.wait_req) begin
			case (AVS_ADDRESS[3:2])
				mode_adr[3:2]: s_d.rdata = {16'h0000, s_q.mode};
				enable_adr[3:2]: s_d.rdata = {30'h0, s_q.en};
				status_adr[3:2]: s_d.rdata = {28'h0, active, flt_lvl};
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_q.mode <= `CAP_MODE_RESET;
			s_q.en <= `CAP_ENABLE_RESET;
			s_q.wait_req <= 1'b1;
			s_q.rdata <= 32'h0;
			s_q.cfg_wr <= 2'h0;
			s_q.lvl_prev <= 2'h0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_ch1_dir_locked: assert property (access && AVS_WRITE && hit_mode && s_q.en[0] |=> $stable(s_q.mode[1:0])) else $error("ch1 direction changed while enabled");
	a_ch2_dir_locked: assert property (access && AVS_WRITE && hit_mode && s_q.en[1] |=> $stable(s_q.mode[9:8])) else $error("ch2 direction changed while enabled");
	a_ch1_dir_decode: assert property (s_q.mode[1:0] == 2'h2 |-> sel_in[0] == TIMER_INPUT_TWO) else $error("ch1 input two not selected");
	a_ch2_dir_decode: assert property (s_q.mode[9:8] == 2'h1 |-> sel_in[1] == TIMER_INPUT_ONE) else $error("ch2 input one not selected");
	a_trig_gate_off: assert property (s_q.mode[1:0] == 2'h3 && !TRIGGER_INPUT_IN_USE |=> !cap[0]) else $error("trigger path ran without trigger input");
	a_ch2_field_map: assert property (g_ch[1].psc_code == s_q.mode[11:10] && g_ch[1].flt_code == s_q.mode[15:12]) else $error("ch2 prescale or filter bits misplaced");
	a_write_one_wait: assert property ((AVS_WRITE && s_q.wait_req) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus answer not one wait state");
	a_disable_no_cap: assert property (!s_q.en[1] |=> !cap[1]) else $error("capture on disabled channel");
	c_ch1_capture: cover property (cap[0]);
	c_ch2_capture: cover property (cap[1] && s_q.mode[9:8] == 2'h3);
	c_locked_write: cover property (access && AVS_WRITE && hit_mode && s_q.en[0]);
endmodule : input_capture_channel_config

// ===== tb/pin_source_model.sv
// Behavioural source for the timer input pins and the trigger source.
`timescale 1ns/10ps
module pin_source_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [2:0] sel,
	input wire logic [9:0] len,
	input wire logic use_in,
	output logic [2:0] pins,
	output logic in_use
);
	logic [9:0] left_q = 10'h000;
	logic [2:0] sel_q = 3'h0;
	// Lines move only after an edge, as a synchronous source would.
	always @(posedge clk) begin
		if (start) begin
			left_q <= len;
			sel_q <= sel;
		end else if (left_q != 10'h000) begin
			left_q <= left_q - 10'h001;
		end
		in_use <= use_in;
	end
	assign pins = (left_q != 10'h000) ? sel_q : 3'h0;
endmodule : pin_source_model

// ===== tb/tb_top.sv
// Self-checking bench for the two capture channel front ends.
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wreq;
	logic start = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [9:0] len = 10'h000;
	logic use_in = 1'b0;
	logic [2:0] pins;
	logic in_use;
	logic [1:0] cap;
	logic [1:0] lvl;
	logic [31:0] q;
	int fail_count = 0;
	int checked = 0;
	int cap1 = 0;
	int cap2 = 0;
	int b1 = 0;
	int b2 = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cap1 += int'(cap[0] === 1'b1);
		cap2 += int'(cap[1] === 1'b1);
	end
	// Byte lanes are tied on, so partial writes go untested.
	input_capture_channel_config u_input_capture_channel_config (
		.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.TIMER_INPUT_ONE(pins[0]), .TIMER_INPUT_TWO(pins[1]),
		.TRIGGER_CAPTURE_SOURCE(pins[2]), .TRIGGER_INPUT_IN_USE(in_use),
		.CAPTURE(cap), .FILTERED_LEVEL(lvl));
	pin_source_model u_pin_source_model (
		.clk(clk), .start(start), .sel(sel), .len(len),
		.use_in(use_in), .pins(pins), .in_use(in_use));
	task automatic conclude;
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 40);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 40) check("bus answer", 32'h1, 32'h0);
	endtask : bus
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check("register", q, e);
	endtask : rdchk
	// Direction bits are locked while enabled, so disable first.
	task automatic cfg(input logic [15:0] m, input logic [1:0] en);
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b1, 4'h0, {16'h0, m});
		bus(1'b1, 4'h4, {30'h0, en});
	endtask : cfg
	task automatic pulse(input logic [2:0] s, input int l, input int gap);
		@(posedge clk);
		start <= 1'b1;
		sel <= s;
		len <= 10'(l);
		@(posedge clk);
		start <= 1'b0;
		repeat (l + gap) @(posedge clk);
	endtask : pulse
	task automatic mark;
		b1 = cap1;
		b2 = cap2;
	endtask : mark
	task automatic caps(input int e1, input int e2);
		check("capture one", 32'(cap1 - b1), 32'(e1));
		check("capture two", 32'(cap2 - b2), 32'(e2));
		mark();
	endtask : caps
	task automatic t_regs;
		rdchk(4'h0, 32'h0);
		rdchk(4'h4, 32'h0);
		rdchk(4'hc, 32'h0);
		cfg(16'h5a6d, 2'h0);
		rdchk(4'h0, 32'h5a6d);
		bus(1'b1, 4'h4, 32'h3);
		bus(1'b1, 4'h0, 32'h0);
		rdchk(4'h0, 32'h0201);
	endtask : t_regs
	task automatic t_psc;
		for (int c = 0; c < 4; c++) begin
			cfg(16'h0201 | 16'(c << 2) | 16'(c << 10), 2'h3);
			mark();
			repeat (8) pulse(3'h3, 2, 4);
			caps(8 >> c, 8 >> c);
		end
	endtask : t_psc
	task automatic t_dir;
		cfg(16'h0102, 2'h3);
		mark();
		pulse(3'h2, 2, 4);
		caps(1, 0);
		cfg(16'h0000, 2'h3);
		pulse(3'h3, 2, 4);
		caps(0, 0);
	endtask : t_dir
	task automatic t_trig;
		cfg(16'h0303, 2'h3);
		mark();
		pulse(3'h4, 2, 4);
		caps(0, 0);
		use_in <= 1'b1;
		pulse(3'h4, 2, 4);
		caps(1, 1);
		use_in <= 1'b0;
	endtask : t_trig
	task automatic t_filter;
		cfg(16'hf111, 2'h3);
		mark();
		pulse(3'h1, 1, 300);
		caps(0, 0);
		pulse(3'h1, 2, 300);
		caps(1, 0);
		pulse(3'h1, 200, 300);
		caps(1, 0);
		pulse(3'h1, 300, 300);
		caps(1, 1);
		cfg(16'ha151, 2'h3);
		mark();
		pulse(3'h1, 14, 300);
		caps(0, 0);
		pulse(3'h1, 80, 300);
		caps(1, 1);
	endtask : t_filter
	// Both filters follow the same pin, so both levels and the status agree.
	task automatic t_level;
		cfg(16'h0101, 2'h1);
		@(posedge clk);
		start <= 1'b1;
		sel <= 3'h1;
		len <= 10'h028;
		@(posedge clk);
		start <= 1'b0;
		repeat (4) @(posedge clk);
		check("filtered level", 32'(lvl), 32'h3);
		rdchk(4'h8, 32'h7);
		repeat (48) @(posedge clk);
		check("filtered level", 32'(lvl), 32'h0);
		rdchk(4'h8, 32'h4);
	endtask : t_level
	task automatic t_restart;
		cfg(16'h0009, 2'h1);
		mark();
		repeat (2) pulse(3'h1, 2, 4);
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b1, 4'h4, 32'h1);
		repeat (3) pulse(3'h1, 2, 4);
		caps(0, 0);
		pulse(3'h1, 2, 4);
		caps(1, 0);
	endtask : t_restart
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_psc();
		t_dir();
		t_trig();
		t_filter();
		t_restart();
		t_level();
		conclude();
	end
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule : tb_top
